// *** hdl/ccpse_pkg.sv ***
// Package: register map, field layout, codes and carrier types of the trigger and pulse block
package ccpse_pkg;
	localparam int AW = 10;
	localparam int IW = 8;

	// Register indices; the byte address is four times the index
	localparam logic [IW-1:0] RI_INTERRUPT_CONTROL = 8'h0b;
	localparam logic [IW-1:0] RI_PERIPHERAL_FLAGS_ONE = 8'h0c;
	localparam logic [IW-1:0] RI_PERIPHERAL_FLAGS_TWO = 8'h0d;
	localparam logic [IW-1:0] RI_TIMER_ONE_LOW = 8'h0e;
	localparam logic [IW-1:0] RI_TIMER_ONE_HIGH = 8'h0f;
	localparam logic [IW-1:0] RI_TIMER_ONE_CONTROL = 8'h10;
	localparam logic [IW-1:0] RI_TIMER_TWO_COUNT = 8'h11;
	localparam logic [IW-1:0] RI_TIMER_TWO_CONTROL = 8'h12;
	localparam logic [IW-1:0] RI_UNIT_A_VALUE_LOW = 8'h15;
	localparam logic [IW-1:0] RI_UNIT_A_VALUE_HIGH = 8'h16;
	localparam logic [IW-1:0] RI_UNIT_A_CONTROL = 8'h17;
	localparam logic [IW-1:0] RI_UNIT_B_VALUE_LOW = 8'h1b;
	localparam logic [IW-1:0] RI_UNIT_B_VALUE_HIGH = 8'h1c;
	localparam logic [IW-1:0] RI_UNIT_B_CONTROL = 8'h1d;
	localparam logic [IW-1:0] RI_ANALOG_CONTROL = 8'h1f;
	localparam logic [IW-1:0] RI_PORT_C_DIRECTION = 8'h87;
	localparam logic [IW-1:0] RI_PERIPHERAL_ENABLES_ONE = 8'h8c;
	localparam logic [IW-1:0] RI_PERIPHERAL_ENABLES_TWO = 8'h8d;
	localparam logic [IW-1:0] RI_TIMER_TWO_PERIOD = 8'h92;

	// Reset values and writable-bit masks
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DIRECTION = 8'hff;
	localparam logic [7:0] RST_PERIOD = 8'hff;
	localparam logic [7:0] MASK_UNIT_CONTROL = 8'h3f;
	localparam logic [7:0] MASK_TIMER_ONE_CONTROL = 8'h3f;
	localparam logic [7:0] MASK_TIMER_TWO_CONTROL = 8'h7f;
	localparam logic [7:0] MASK_FLAGS_TWO = 8'h01;
	localparam logic [7:0] MASK_ANALOG = 8'h03;

	// Field positions
	localparam int MODE_HI = 3;
	localparam int DUTY_LSB_HI = 5;
	localparam int DUTY_LSB_LO = 4;
	localparam int T2_ON = 2;
	localparam int T2_PS_HI = 1;
	localparam int T2_POST_HI = 6;
	localparam int T2_POST_LO = 3;
	localparam int T1_ON = 0;
	localparam int T1_PS_HI = 5;
	localparam int T1_PS_LO = 4;
	localparam int F1_T1_OVF = 0;
	localparam int F1_T2 = 1;
	localparam int F1_UNIT_A = 2;
	localparam int F2_UNIT_B = 0;
	localparam int AN_ENABLE = 0;
	localparam int AN_STARTED = 1;
	localparam int DIR_UNIT_A = 2;
	localparam int DIR_UNIT_B = 1;

	// Mode codes, phase and prescale codes, bus answers
	localparam logic [3:0] MODE_OFF = 4'h0;
	localparam logic [3:0] MODE_TRIGGER = 4'hb;
	localparam logic [1:0] MODE_TOP_CMP = 2'h2;
	localparam logic [1:0] MODE_TOP_PWM = 2'h3;
	localparam logic [1:0] LOW_LAST = 2'h3;
	localparam logic [1:0] PS_ONE = 2'h0;
	localparam logic [1:0] PS_FOUR = 2'h1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic en;
		logic [IW-1:0] idx;
		logic [7:0] data;
	} ccpse_wr_t;

	typedef struct packed {
		logic period_start;
		logic step;
		logic [9:0] next;
		logic [15:0] t1;
	} ccpse_tb_t;

	function automatic logic ccpse_is_pwm(input logic [3:0] mode);
		return mode[3:2] == MODE_TOP_PWM;
	endfunction

	function automatic logic ccpse_mapped(input logic [IW-1:0] idx);
		case (idx)
			RI_INTERRUPT_CONTROL, RI_PERIPHERAL_FLAGS_ONE, RI_PERIPHERAL_FLAGS_TWO,
			RI_TIMER_ONE_LOW, RI_TIMER_ONE_HIGH, RI_TIMER_ONE_CONTROL,
			RI_TIMER_TWO_COUNT, RI_TIMER_TWO_CONTROL, RI_TIMER_TWO_PERIOD,
			RI_UNIT_A_VALUE_LOW, RI_UNIT_A_VALUE_HIGH, RI_UNIT_A_CONTROL,
			RI_UNIT_B_VALUE_LOW, RI_UNIT_B_VALUE_HIGH, RI_UNIT_B_CONTROL,
			RI_ANALOG_CONTROL, RI_PORT_C_DIRECTION,
			RI_PERIPHERAL_ENABLES_ONE, RI_PERIPHERAL_ENABLES_TWO: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
endpackage

// *** hdl/ccpse_axil.sv ***
`timescale 1ns/1ps
// AXI4-Lite slave: turns bus traffic into byte register writes and reads
module ccpse_axil (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ccpse_pkg::AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ccpse_pkg::AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output ccpse_pkg::ccpse_wr_t wr,
	output logic [ccpse_pkg::IW-1:0] rd_idx,
	input wire logic [7:0] rd_data
);
	import ccpse_pkg::*;
	logic aw_full_r;
	logic w_full_r;
	logic lane_r;
	logic [IW-1:0] aw_idx_r;
	logic [7:0] w_data_r;
	logic both;

	// Address and data are held separately until both have arrived
	assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
	assign s_axi_wready = !w_full_r && !s_axi_bvalid;
	assign both = aw_full_r && w_full_r;
	assign wr = '{en: both && lane_r && ccpse_mapped(aw_idx_r), idx: aw_idx_r, data: w_data_r};
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_idx = s_axi_araddr[AW-1:2];

	// Write address holder
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			aw_idx_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full_r <= 1'b1;
			aw_idx_r <= s_axi_awaddr[AW-1:2];
		end else if (both) begin
			aw_full_r <= 1'b0;
		end
	end

	// Write data holder; only the low byte lane carries register data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_r <= 1'b0;
			w_data_r <= '0;
			lane_r <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full_r <= 1'b1;
			w_data_r <= s_axi_wdata[7:0];
			lane_r <= s_axi_wstrb[0];
		end else if (both) begin
			w_full_r <= 1'b0;
		end
	end

	// Write response, error for an unmapped index
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (both) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= ccpse_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_data};
			s_axi_rresp <= ccpse_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// *** hdl/ccpse_unit.sv ***
`timescale 1ns/1ps
// One capture/compare/pulse unit: compare match and double-buffered pulse output
module ccpse_unit (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] ctl,
	input wire logic [7:0] pend,
	input wire ccpse_pkg::ccpse_wr_t hwr,
	input wire ccpse_pkg::ccpse_tb_t tb,
	output logic [7:0] active,
	output logic pin,
	output logic match
);
	import ccpse_pkg::*;
	logic [1:0] lsb_r;
	logic eq_r;
	logic eq;
	logic pwm;
	logic off;
	logic [9:0] duty;

	assign pwm = ccpse_is_pwm(ctl[MODE_HI:0]);
	assign off = ctl[MODE_HI:0] == MODE_OFF;
	assign duty = {active, lsb_r};
	assign eq = (ctl[MODE_HI:2] == MODE_TOP_CMP) && ({active, pend} == tb.t1);
	assign match = eq && !eq_r;

	// Active byte: bus-written outside pulse mode, period-start copy inside it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			active <= '0;
		end else if (pwm && tb.period_start) begin
			active <= pend;
		end else if (!pwm && hwr.en) begin
			active <= hwr.data;
		end
	end

	// Hidden two low duty bits, cleared when the unit is off
	always_ff @(posedge aclk) begin
		if (!aresetn || off) begin
			lsb_r <= '0;
		end else if (pwm && tb.period_start) begin
			lsb_r <= ctl[DUTY_LSB_HI:DUTY_LSB_LO];
		end
	end

	// Match edge detect so a held equality flags once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eq_r <= 1'b0;
		end else begin
			eq_r <= eq;
		end
	end

	// Pulse output latch
	always_ff @(posedge aclk) begin
		if (!aresetn || off || !pwm) begin
			pin <= 1'b0;
		end else if (tb.period_start) begin
			pin <= ({pend, ctl[DUTY_LSB_HI:DUTY_LSB_LO]} != 10'h000);
		end else if (tb.step && tb.next == duty) begin
			pin <= 1'b0;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_zero_duty;
		pwm && tb.period_start && {pend, ctl[DUTY_LSB_HI:DUTY_LSB_LO]} == 10'h000 |=> !pin;
	endproperty
	a_zero_duty: assert property (p_zero_duty) else $error("pin set at zero duty");

	property p_high_ro;
		pwm && !tb.period_start |=> active == $past(active);
	endproperty
	a_high_ro: assert property (p_high_ro) else $error("active byte changed");

	property p_duty_end;
		pwm && !off && !tb.period_start && tb.step && tb.next == duty |=> !pin;
	endproperty
	a_duty_end: assert property (p_duty_end) else $error("pin not cleared");
endmodule

// *** hdl/ccpse_top.sv ***
`timescale 1ns/1ps
// Top: registers, timer one, timer two time base and both units
// Operation
// - Unit A trigger clears timer one
// - Unit B trigger clears timer, starts conversion
// - Trigger clear never sets overflow flag
// - Pulse mode drives up to 10-bit waveform
// - Control cleared forces pulse latch low
// - Period is (period+1) times 4 times prescale
// - Period match clears timer two, restarts
// - Period start sets pin unless duty zero
// - Period start copies pending duty to active
// - Postscaler only paces timer two flag
// - Duty is pending byte plus two bits
// - Duty writable anytime, applied next period
// - Active duty byte read-only in pulse mode
// - Pin clears when duty equals time base
// - Duty beyond period keeps pin high
// - Timer two prescale of 1, 4, 16
// - Resolution is log2 of oscillator over pulse
// - Trigger mode flags match, pin unchanged
// - Mode zero disables and resets unit
// - Both units share timer two base
module ccpse_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ccpse_pkg::AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ccpse_pkg::AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic unit_a_pin,
	output logic unit_a_pin_oe,
	output logic unit_b_pin,
	output logic unit_b_pin_oe,
	output logic adc_start
);
	import ccpse_pkg::*;
	ccpse_wr_t wr;
	ccpse_wr_t a_hwr;
	ccpse_wr_t b_hwr;
	ccpse_tb_t tb;
	logic [IW-1:0] rd_idx;
	logic [7:0] rd_data;
	logic [7:0] intr_ctl_r;
	logic [7:0] flags1_r;
	logic [7:0] flags2_r;
	logic [7:0] en1_r;
	logic [7:0] en2_r;
	logic [7:0] dir_r;
	logic [7:0] analog_r;
	logic [15:0] t1_r;
	logic [7:0] t1_ctl_r;
	logic [2:0] t1pre_r;
	logic [2:0] t1_mask;
	logic [7:0] t2_r;
	logic [7:0] t2_nxt;
	logic [7:0] t2_ctl_r;
	logic [7:0] t2_period_r;
	logic [1:0] q_r;
	logic [1:0] q_nxt;
	logic [3:0] pre_r;
	logic [3:0] pre_nxt;
	logic [3:0] post_r;
	logic [1:0] low;
	logic [1:0] low_nxt;
	logic [7:0] a_low_r;
	logic [7:0] a_ctl_r;
	logic [7:0] b_low_r;
	logic [7:0] b_ctl_r;
	logic [7:0] a_high;
	logic [7:0] b_high;
	logic a_match;
	logic b_match;
	logic a_trig;
	logic b_trig;
	logic t1_trig;
	logic t1_inc;
	logic t1_ovf;
	logic t1_wr;
	logic inst_tick;
	logic t2_on;
	logic step;
	logic t2_inc;
	logic period_match;
	logic post_fire;
	logic adc_fire;
	logic [7:0] set1;

	function automatic logic hit(input ccpse_wr_t w, input logic [IW-1:0] idx);
		return w.en && (w.idx == idx);
	endfunction

	ccpse_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr(wr),
		.rd_idx(rd_idx),
		.rd_data(rd_data)
	);

	// Both units see one shared time base
	assign a_hwr = '{en: hit(wr, RI_UNIT_A_VALUE_HIGH), idx: wr.idx, data: wr.data};
	assign b_hwr = '{en: hit(wr, RI_UNIT_B_VALUE_HIGH), idx: wr.idx, data: wr.data};
	assign tb = '{period_start: period_match, step: step, next: {t2_nxt, low_nxt}, t1: t1_r};

	ccpse_unit u_unit_a (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl(a_ctl_r),
		.pend(a_low_r),
		.hwr(a_hwr),
		.tb(tb),
		.active(a_high),
		.pin(unit_a_pin),
		.match(a_match)
	);

	ccpse_unit u_unit_b (
		.aclk(aclk),
		.aresetn(aresetn),
		.ctl(b_ctl_r),
		.pend(b_low_r),
		.hwr(b_hwr),
		.tb(tb),
		.active(b_high),
		.pin(unit_b_pin),
		.match(b_match)
	);

	// Pins drive only while their direction bit is cleared
	assign unit_a_pin_oe = !dir_r[DIR_UNIT_A];
	assign unit_b_pin_oe = !dir_r[DIR_UNIT_B];

	// Quarter-rate instruction tick from the Q phase
	assign q_nxt = q_r + 2'h1;
	assign inst_tick = q_r == LOW_LAST;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	// Timer two prescale: low two time-base bits from Q or prescaler
	assign t2_on = t2_ctl_r[T2_ON];
	assign pre_nxt = !t2_on ? 4'h0 : inst_tick ? pre_r + 4'h1 : pre_r;
	always_comb begin
		case (t2_ctl_r[T2_PS_HI:0])
			PS_ONE: begin
				step = t2_on;
				low = q_r;
				low_nxt = q_nxt;
			end
			PS_FOUR: begin
				step = t2_on && inst_tick;
				low = pre_r[1:0];
				low_nxt = pre_nxt[1:0];
			end
			default: begin
				step = t2_on && inst_tick && pre_r[1:0] == LOW_LAST;
				low = pre_r[3:2];
				low_nxt = pre_nxt[3:2];
			end
		endcase
	end

	// Period match restarts timer two and the pulse
	assign t2_inc = step && low == LOW_LAST;
	assign period_match = t2_inc && t2_r == t2_period_r;
	assign t2_nxt = period_match ? 8'h00 : t2_inc ? t2_r + 8'h01 : t2_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_nxt;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t2_r <= RST_ZERO;
		end else if (hit(wr, RI_TIMER_TWO_COUNT)) begin
			t2_r <= wr.data;
		end else begin
			t2_r <= t2_nxt;
		end
	end

	// Postscaler paces only the timer two flag
	assign post_fire = period_match && post_r == t2_ctl_r[T2_POST_HI:T2_POST_LO];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			post_r <= '0;
		end else if (post_fire) begin
			post_r <= '0;
		end else if (period_match) begin
			post_r <= post_r + 4'h1;
		end
	end

	// Timer one prescale 1, 2, 4, 8 of the instruction tick
	always_comb begin
		case (t1_ctl_r[T1_PS_HI:T1_PS_LO])
			2'h0: t1_mask = 3'h0;
			2'h1: t1_mask = 3'h1;
			2'h2: t1_mask = 3'h3;
			default: t1_mask = 3'h7;
		endcase
	end
	assign t1_inc = t1_ctl_r[T1_ON] && inst_tick && (t1pre_r & t1_mask) == t1_mask;
	always_ff @(posedge aclk) begin
		if (!aresetn || !t1_ctl_r[T1_ON]) begin
			t1pre_r <= '0;
		end else if (inst_tick) begin
			t1pre_r <= t1pre_r + 3'h1;
		end
	end

	// Trigger-mode matches; unit B also asks for a conversion
	assign a_trig = a_match && a_ctl_r[MODE_HI:0] == MODE_TRIGGER;
	assign b_trig = b_match && b_ctl_r[MODE_HI:0] == MODE_TRIGGER;
	assign t1_trig = a_trig || b_trig;
	assign t1_wr = hit(wr, RI_TIMER_ONE_LOW) || hit(wr, RI_TIMER_ONE_HIGH);
	assign t1_ovf = t1_inc && !t1_trig && !t1_wr && t1_r == 16'hffff;
	assign adc_fire = b_trig && analog_r[AN_ENABLE];

	// Timer one pair: bus write, then trigger clear, then count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			t1_r <= '0;
		end else if (hit(wr, RI_TIMER_ONE_LOW)) begin
			t1_r[7:0] <= wr.data;
		end else if (hit(wr, RI_TIMER_ONE_HIGH)) begin
			t1_r[15:8] <= wr.data;
		end else if (t1_trig) begin
			t1_r <= '0;
		end else if (t1_inc) begin
			t1_r <= t1_r + 16'h0001;
		end
	end

	// Conversion start pulse and sticky started bit
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			adc_start <= 1'b0;
		end else begin
			adc_start <= adc_fire;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			analog_r <= RST_ZERO;
		end else begin
			if (hit(wr, RI_ANALOG_CONTROL)) begin
				analog_r[AN_ENABLE] <= wr.data[AN_ENABLE];
			end
			if (adc_fire) begin
				analog_r[AN_STARTED] <= 1'b1;
			end else if (hit(wr, RI_ANALOG_CONTROL) && wr.data[AN_STARTED]) begin
				analog_r[AN_STARTED] <= 1'b0;
			end
		end
	end

	// Event flags: hardware set wins over a software write
	always_comb begin
		set1 = '0;
		set1[F1_T1_OVF] = t1_ovf;
		set1[F1_T2] = post_fire;
		set1[F1_UNIT_A] = a_match;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags1_r <= RST_ZERO;
			flags2_r <= RST_ZERO;
		end else begin
			flags1_r <= (hit(wr, RI_PERIPHERAL_FLAGS_ONE) ? wr.data : flags1_r) | set1;
			if (b_match) begin
				flags2_r[F2_UNIT_B] <= 1'b1;
			end else if (hit(wr, RI_PERIPHERAL_FLAGS_TWO)) begin
				flags2_r <= wr.data & MASK_FLAGS_TWO;
			end
		end
	end

	// Plain software registers: controls, duty bytes, period, direction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			intr_ctl_r <= RST_ZERO;
			en1_r <= RST_ZERO;
			en2_r <= RST_ZERO;
			dir_r <= RST_DIRECTION;
			t1_ctl_r <= RST_ZERO;
			t2_ctl_r <= RST_ZERO;
			t2_period_r <= RST_PERIOD;
			a_low_r <= RST_ZERO;
			a_ctl_r <= RST_ZERO;
			b_low_r <= RST_ZERO;
			b_ctl_r <= RST_ZERO;
		end else if (wr.en) begin
			case (wr.idx)
				RI_INTERRUPT_CONTROL: intr_ctl_r <= wr.data;
				RI_PERIPHERAL_ENABLES_ONE: en1_r <= wr.data;
				RI_PERIPHERAL_ENABLES_TWO: en2_r <= wr.data & MASK_FLAGS_TWO;
				RI_PORT_C_DIRECTION: dir_r <= wr.data;
				RI_TIMER_ONE_CONTROL: t1_ctl_r <= wr.data & MASK_TIMER_ONE_CONTROL;
				RI_TIMER_TWO_CONTROL: t2_ctl_r <= wr.data & MASK_TIMER_TWO_CONTROL;
				RI_TIMER_TWO_PERIOD: t2_period_r <= wr.data;
				RI_UNIT_A_VALUE_LOW: a_low_r <= wr.data;
				RI_UNIT_A_CONTROL: a_ctl_r <= wr.data & MASK_UNIT_CONTROL;
				RI_UNIT_B_VALUE_LOW: b_low_r <= wr.data;
				RI_UNIT_B_CONTROL: b_ctl_r <= wr.data & MASK_UNIT_CONTROL;
				default: ;
			endcase
		end
	end

	// Read mux; unmapped indices read zero
	always_comb begin
		case (rd_idx)
			RI_INTERRUPT_CONTROL: rd_data = intr_ctl_r;
			RI_PERIPHERAL_FLAGS_ONE: rd_data = flags1_r;
			RI_PERIPHERAL_FLAGS_TWO: rd_data = flags2_r;
			RI_TIMER_ONE_LOW: rd_data = t1_r[7:0];
			RI_TIMER_ONE_HIGH: rd_data = t1_r[15:8];
			RI_TIMER_ONE_CONTROL: rd_data = t1_ctl_r;
			RI_TIMER_TWO_COUNT: rd_data = t2_r;
			RI_TIMER_TWO_CONTROL: rd_data = t2_ctl_r;
			RI_TIMER_TWO_PERIOD: rd_data = t2_period_r;
			RI_UNIT_A_VALUE_LOW: rd_data = a_low_r;
			RI_UNIT_A_VALUE_HIGH: rd_data = a_high;
			RI_UNIT_A_CONTROL: rd_data = a_ctl_r;
			RI_UNIT_B_VALUE_LOW: rd_data = b_low_r;
			RI_UNIT_B_VALUE_HIGH: rd_data = b_high;
			RI_UNIT_B_CONTROL: rd_data = b_ctl_r;
			RI_ANALOG_CONTROL: rd_data = analog_r & MASK_ANALOG;
			RI_PORT_C_DIRECTION: rd_data = dir_r;
			RI_PERIPHERAL_ENABLES_ONE: rd_data = en1_r;
			RI_PERIPHERAL_ENABLES_TWO: rd_data = en2_r;
			default: rd_data = RST_ZERO;
		endcase
	end

	// Checking aid: cycles between period matches under steady settings
	logic [15:0] per_cnt_r;
	logic per_seen_r;
	logic [15:0] per_exp;
	logic cfg_wr;
	assign cfg_wr = hit(wr, RI_TIMER_TWO_COUNT) || hit(wr, RI_TIMER_TWO_PERIOD)
		|| hit(wr, RI_TIMER_TWO_CONTROL);
	assign per_exp = ({8'h00, t2_period_r} + 16'h0001)
		<< (t2_ctl_r[T2_PS_HI:0] == PS_ONE ? 2 : t2_ctl_r[T2_PS_HI:0] == PS_FOUR ? 4 : 6);
	always_ff @(posedge aclk) begin
		if (!aresetn || cfg_wr) begin
			per_cnt_r <= '0;
			per_seen_r <= 1'b0;
		end else if (period_match) begin
			per_cnt_r <= '0;
			per_seen_r <= 1'b1;
		end else begin
			per_cnt_r <= per_cnt_r + 16'h0001;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_period;
		period_match && per_seen_r && !cfg_wr |-> per_cnt_r + 16'h0001 == per_exp;
	endproperty
	a_period: assert property (p_period) else $error("pulse period wrong");

	property p_t1_clear;
		a_trig && !t1_wr |=> t1_r == 16'h0000;
	endproperty
	a_t1_clear: assert property (p_t1_clear) else $error("timer one not cleared");

	property p_adc;
		b_trig && analog_r[AN_ENABLE] |=> adc_start ##1 !adc_start;
	endproperty
	a_adc: assert property (p_adc) else $error("conversion start missing");

	property p_no_ovf;
		t1_trig && !flags1_r[F1_T1_OVF] && !hit(wr, RI_PERIPHERAL_FLAGS_ONE)
			|=> !flags1_r[F1_T1_OVF];
	endproperty
	a_no_ovf: assert property (p_no_ovf) else $error("overflow flag set by trigger");

	property p_off_low;
		a_ctl_r[MODE_HI:0] == MODE_OFF |=> !unit_a_pin;
	endproperty
	a_off_low: assert property (p_off_low) else $error("pin high while off");

	property p_wrap;
		period_match && !hit(wr, RI_TIMER_TWO_COUNT) |=> t2_r == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("timer two not cleared");

	property p_load;
		ccpse_is_pwm(a_ctl_r[MODE_HI:0]) && period_match |=> a_high == $past(a_low_r);
	endproperty
	a_load: assert property (p_load) else $error("duty not transferred");

	c_pwm_start: cover property (period_match && ccpse_is_pwm(a_ctl_r[MODE_HI:0]) ##1 unit_a_pin);
	c_adc: cover property (adc_fire);
	c_ovf: cover property (t1_ovf);
endmodule

// *** tb/ccpse_load.sv ***
`timescale 1ns/1ps
// Pin load: measures the high time and the period of a pulse output
module ccpse_load (
	input wire logic aclk,
	input wire logic pin,
	output int high_cnt,
	output int period_cnt
);
	int h = 0;
	int p = 0;
	logic prev = 1'b0;
	// Latch both counts at each rising edge of the pin, then restart them;
	// sampled on the falling clock edge, clear of the edge that moves the pin
	always @(negedge aclk) begin
		if (pin && !prev) begin
			high_cnt = h;
			period_cnt = p;
			h = 1;
			p = 1;
		end else begin
			h = h + int'(pin);
			p = p + 1;
		end
		prev = pin;
	end
endmodule

// *** tb/ccpse_top_tb.sv ***
`timescale 1ns/1ps
// Testbench: register access, pulse output and trigger checks
module ccpse_top_tb;
	import ccpse_pkg::*;
	`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
		$display("unexpected %s exp %h got %h", n, e, s); end end
	localparam int PR = 3;
	localparam int DUTY = 6;
	logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic unit_a_pin, unit_a_pin_oe, unit_b_pin, unit_b_pin_oe, adc_start;
	logic [7:0] d;
	int error_cnt = 0, comparisons = 0, high_cnt, period_cnt, adc_cnt = 0, n;
	ccpse_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.unit_a_pin(unit_a_pin), .unit_a_pin_oe(unit_a_pin_oe),
		.unit_b_pin(unit_b_pin), .unit_b_pin_oe(unit_b_pin_oe), .adc_start(adc_start));
	ccpse_load i_load (.aclk(aclk), .pin(unit_a_pin), .high_cnt(high_cnt),
		.period_cnt(period_cnt));
	// Count conversion start pulses
	always @(negedge aclk) if (adc_start) adc_cnt++;
	// 25 MHz clock
	always #20 aclk = ~aclk;
	// Bus write: address and data offered together, each released once taken
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		logic a, w, b;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		b = 1'b0;
		while (!b) begin
			@(negedge aclk);
			a = s_axi_awready & s_axi_awvalid;
			w = s_axi_wready & s_axi_wvalid;
			b = s_axi_bvalid;
			@(posedge aclk);
			if (a) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask
	// Bus read, then compare the byte with its expected value
	task automatic rc(input logic [7:0] i, input logic [7:0] e);
		logic a, v;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		v = 1'b0;
		while (!v) begin
			@(negedge aclk);
			a = s_axi_arready & s_axi_arvalid;
			v = s_axi_rvalid;
			d = s_axi_rdata[7:0];
			r = s_axi_rresp;
			@(posedge aclk);
			if (a) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		`CHK("register", e, d)
	endtask
	// Verdict and end of run
	task automatic end_of_test;
		if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		end_of_test;
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(RI_PORT_C_DIRECTION, RST_DIRECTION);
		rc(RI_TIMER_TWO_PERIOD, RST_PERIOD);
		rc(RI_UNIT_A_CONTROL, RST_ZERO);
		rc(8'h40, 8'h00);
		`CHK("rresp", RESP_SLVERR, r)
		wr(RI_TIMER_TWO_PERIOD, 8'(PR));
		wr(RI_UNIT_A_VALUE_LOW, 8'(DUTY >> 2));
		wr(RI_UNIT_A_CONTROL, {2'b00, 2'(DUTY), MODE_OFF});
		wr(RI_PORT_C_DIRECTION, 8'hfb);
		`CHK("oe", 1'b1, unit_a_pin_oe)
		`CHK("oe_b", 1'b0, unit_b_pin_oe)
		wr(RI_TIMER_TWO_CONTROL, 8'h04);
		wr(RI_UNIT_A_CONTROL, {2'b00, 2'(DUTY), 4'hd});
		repeat (80) @(posedge aclk);
		`CHK("high", DUTY, high_cnt)
		`CHK("period", (PR + 1) * 4, period_cnt)
		rc(RI_UNIT_A_VALUE_HIGH, 8'(DUTY >> 2));
		wr(RI_UNIT_A_VALUE_HIGH, 8'h55);
		rc(RI_UNIT_A_VALUE_HIGH, 8'(DUTY >> 2));
		wr(RI_TIMER_TWO_CONTROL, 8'h05);
		repeat (200) @(posedge aclk);
		`CHK("high", DUTY * 4, high_cnt)
		`CHK("period", (PR + 1) * 16, period_cnt)
		// Clear the control while the pin is high, well before the duty would end
		@(posedge unit_a_pin);
		wr(RI_UNIT_A_CONTROL, 8'h00);
		@(negedge aclk);
		`CHK("pin", 1'b0, unit_a_pin)
		wr(RI_ANALOG_CONTROL, 8'h01);
		wr(RI_UNIT_B_VALUE_LOW, 8'h10);
		wr(RI_UNIT_B_CONTROL, {4'h0, MODE_TRIGGER});
		wr(RI_TIMER_ONE_CONTROL, 8'h01);
		repeat (1200) @(posedge aclk);
		rc(RI_TIMER_ONE_HIGH, 8'h00);
		rc(RI_PERIPHERAL_FLAGS_TWO, 8'h01);
		rc(RI_ANALOG_CONTROL, 8'h03);
		`CHK("adc", 1'b1, adc_cnt != 0)
		rc(RI_PERIPHERAL_FLAGS_ONE, 8'h02);
		// Converter off: unit B still flags but starts nothing
		wr(RI_ANALOG_CONTROL, 8'h00);
		wr(RI_ANALOG_CONTROL, 8'h02);
		wr(RI_PERIPHERAL_FLAGS_TWO, 8'h00);
		n = adc_cnt;
		repeat (300) @(posedge aclk);
		rc(RI_PERIPHERAL_FLAGS_TWO, 8'h01);
		rc(RI_ANALOG_CONTROL, 8'h00);
		`CHK("adc", n, adc_cnt)
		// Unit A clears timer one at 8, so unit B never reaches its value again
		wr(RI_UNIT_A_VALUE_HIGH, 8'h00);
		wr(RI_UNIT_A_VALUE_LOW, 8'h08);
		wr(RI_UNIT_A_CONTROL, {4'h0, MODE_TRIGGER});
		repeat (300) @(posedge aclk);
		wr(RI_PERIPHERAL_FLAGS_TWO, 8'h00);
		repeat (300) @(posedge aclk);
		rc(RI_PERIPHERAL_FLAGS_TWO, 8'h00);
		rc(RI_PERIPHERAL_FLAGS_ONE, 8'h06);
		`CHK("pin", 1'b0, unit_a_pin)
		`CHK("pin_b", 1'b0, unit_b_pin)
		end_of_test;
	end
endmodule
